// ==== csor_pkg.sv ====
// constants and types for the converter status and overrange register bank
package csor_pkg;
  localparam logic [11:0] ADDR_LINK_STATUS = 12'h208;
  localparam logic [11:0] ADDR_POWER_DOWN = 12'h209;
  localparam logic [11:0] ADDR_OVR_THR_ZERO = 12'h211;
  localparam logic [11:0] ADDR_OVR_THR_ONE = 12'h212;
  localparam logic [11:0] ADDR_OVR_CONFIG = 12'h213;
  localparam logic [11:0] ADDR_SILICON_REV = 12'h297;
  localparam logic [11:0] ADDR_TIMING_CAL = 12'h2B0;

  localparam int BIT_SYNC_STATUS = 5;
  localparam int BIT_REPHASE = 4;
  localparam int BIT_PHASE_SET = 3;
  localparam int BIT_PD_B = 1;
  localparam int BIT_PD_A = 0;
  localparam int BIT_OVERRANGE_PIN_ENABLE = 3;
  localparam int BIT_CAL_EN = 0;

  localparam logic [7:0] RST_THR_ZERO = 8'hF2;
  localparam logic [7:0] RST_THR_ONE = 8'hAB;
  localparam logic [2:0] RST_EXPONENT = 3'h7;
  localparam logic [7:0] RST_ZERO8 = 8'h00;
  // arbitrary neutral default for the spin code
  localparam logic [4:0] SPIN_DEFAULT = 5'h15;

  localparam logic [10:0] PULSE_BASE = 11'h008;
  localparam int CAL_TIME_NS = 2000;
  localparam int CLK_PERIOD_NS = 10;
  localparam int CAL_CYCLES = CAL_TIME_NS / CLK_PERIOD_NS;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [11:0] addr;
    logic [7:0] wdata;
  } csor_req_t;

  typedef struct packed {
    logic [11:0] a;
    logic [11:0] b;
  } csor_samples_t;

  typedef enum logic [1:0] {CAL_IDLE, CAL_RUN, CAL_DONE} csor_cal_state_t;
endpackage

// ==== csor_stretch.sv ====
// one overrange pin: threshold compare and pulse stretch
`timescale 1ns/1ps
`default_nettype none
module csor_stretch
  import csor_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic [7:0] magnitude,
  input wire logic [7:0] threshold,
  input wire logic enable,
  input wire logic [2:0] exponent,
  output logic pin_q
);
  logic [10:0] count_q;
  logic hit;
  assign hit = magnitude >= threshold;

  always_ff @(posedge clk)
  begin
    if (!resetn)
      count_q <= '0;
    else if (hit)
      count_q <= PULSE_BASE << exponent;
    else if (count_q != '0)
      count_q <= count_q - 11'h001;
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
      pin_q <= 1'b0;
    else
      pin_q <= enable && (hit || count_q > 11'h001);
  end

  logic [10:0] len_q;
  always_ff @(posedge clk)
  begin
    if (!resetn || !pin_q)
      len_q <= '0;
    else if (len_q != '1)
      len_q <= len_q + 11'h001;
  end

  // length counter saturates so a very long pulse cannot wrap it
  pulse_len_a: assert property (@(posedge clk)
    disable iff (!resetn)
    $fell(pin_q) && $past(enable, 2) && enable
    |-> $past(len_q) >= (PULSE_BASE << exponent) - 11'h001)
    else $error("overrange pulse shorter than minimum");
endmodule
`default_nettype wire

// ==== csor_regs.sv ====
// converter status, power-down, overrange and timing calibration registers
// Functional notes
// - status bit 5 shows live sync level: 0 asserted, 1 de-asserted.
// - rephase flag bit 4 set on realign; write 1 clears, alarm untouched.
// - phase flag bit 3 set by sysref edge with link on; write 1 clears.
// - bit 1 powers down channel B, bit 0 channel A; reset 0.
// - powered-down channel disables its fourteen lanes.
// - threshold zero, reset F2, raises flag zero at or above it.
// - threshold one, reset AB, raises flag one at or above it.
// - pin enable bit 3 passes flags to pins; else pins held low.
// - pin pulse lasts at least 8 times 2 to the exponent cycles.
// - read-only 5-bit spin code loaded from fuses.
// - calibration enable 0 makes delay follow the manual register.
// - calibration enable 1 calibrates automatically, ignoring manual delay.
// - rising edge of calibration enable starts one calibration run.
// - done flag reads 1 only with enable 1 and run finished.
`timescale 1ns/1ps
`default_nettype none
module csor_regs
  import csor_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire csor_req_t req,
  output logic [7:0] rdata_q,
  input wire logic sync_pin,
  input wire logic sysref_edge,
  input wire logic realign_event,
  input wire logic link_enable,
  input wire logic [4:0] fuse_spin,
  input wire csor_samples_t samples,
  input wire logic [16:0] manual_delay,
  input wire logic [16:0] cal_result,
  output logic chan_a_powerdown_q,
  output logic chan_b_powerdown_q,
  output logic [13:0] chan_a_lane_en_q,
  output logic [13:0] chan_b_lane_en_q,
  output logic chan_a_pin_zero,
  output logic chan_a_pin_one,
  output logic chan_b_pin_zero,
  output logic chan_b_pin_one,
  output logic [16:0] aperture_delay_q,
  output logic timing_cal_complete_q,
  output logic rephase_alarm_q
);
  logic sync_meta_q, sync_q;
  logic rephase_q, phase_set_q;
  logic [7:0] thr_zero_q, thr_one_q;
  logic overrange_pin_enable_q;
  logic [2:0] pulse_stretch_exponent_q;
  logic [4:0] silicon_revision_id_q;
  logic timing_cal_start_q, cal_en_prev_q;
  csor_cal_state_t cal_state_q;
  logic [15:0] cal_cnt_q;
  logic cal_launch;

  function automatic logic wr_at(input csor_req_t r, input logic [11:0] a);
    return r.wr && r.addr == a;
  endfunction

  function automatic logic [7:0] mag8(input logic [11:0] s);
    logic [11:0] m;
    m = s[11] ? 12'(~s + 12'h001) : s;
    if (s == 12'h800)
      m = 12'h7FF;
    return m[10:3];
  endfunction

  // sync pin synchroniser
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      sync_meta_q <= 1'b1;
      sync_q <= 1'b1;
    end
    else
    begin
      sync_meta_q <= sync_pin;
      sync_q <= sync_meta_q;
    end
  end

  // sticky flags, set beats clear
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      rephase_q <= 1'b0;
      phase_set_q <= 1'b0;
      rephase_alarm_q <= 1'b0;
    end
    else
    begin
      if (realign_event)
        rephase_q <= 1'b1;
      else if (wr_at(req, ADDR_LINK_STATUS) && req.wdata[BIT_REPHASE])
        rephase_q <= 1'b0;
      if (realign_event)
        rephase_alarm_q <= 1'b1;
      if (sysref_edge && link_enable)
        phase_set_q <= 1'b1;
      else if (wr_at(req, ADDR_LINK_STATUS) && req.wdata[BIT_PHASE_SET])
        phase_set_q <= 1'b0;
    end
  end

  // plain read/write configuration
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      chan_a_powerdown_q <= 1'b0;
      chan_b_powerdown_q <= 1'b0;
      thr_zero_q <= RST_THR_ZERO;
      thr_one_q <= RST_THR_ONE;
      overrange_pin_enable_q <= 1'b0;
      pulse_stretch_exponent_q <= RST_EXPONENT;
      timing_cal_start_q <= 1'b0;
    end
    else
    begin
      if (wr_at(req, ADDR_POWER_DOWN))
      begin
        chan_a_powerdown_q <= req.wdata[BIT_PD_A];
        chan_b_powerdown_q <= req.wdata[BIT_PD_B];
      end
      if (wr_at(req, ADDR_OVR_THR_ZERO))
        thr_zero_q <= req.wdata;
      if (wr_at(req, ADDR_OVR_THR_ONE))
        thr_one_q <= req.wdata;
      if (wr_at(req, ADDR_OVR_CONFIG))
      begin
        overrange_pin_enable_q <= req.wdata[BIT_OVERRANGE_PIN_ENABLE];
        pulse_stretch_exponent_q <= req.wdata[2:0];
      end
      if (wr_at(req, ADDR_TIMING_CAL))
        timing_cal_start_q <= req.wdata[BIT_CAL_EN];
    end
  end

  // spin code sampled from fuses every cycle after reset release
  always_ff @(posedge clk)
  begin
    if (!resetn)
      silicon_revision_id_q <= SPIN_DEFAULT;
    else
      silicon_revision_id_q <= fuse_spin;
  end

  // lane enables follow channel power-down
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      chan_a_lane_en_q <= '1;
      chan_b_lane_en_q <= '1;
    end
    else
    begin
      chan_a_lane_en_q <= {14{~chan_a_powerdown_q}};
      chan_b_lane_en_q <= {14{~chan_b_powerdown_q}};
    end
  end

  // timing calibration sequencer
  assign cal_launch = timing_cal_start_q && !cal_en_prev_q;

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      cal_en_prev_q <= 1'b0;
      cal_state_q <= CAL_IDLE;
      cal_cnt_q <= '0;
    end
    else
    begin
      cal_en_prev_q <= timing_cal_start_q;
      case (cal_state_q)
        CAL_IDLE:
          if (cal_launch)
          begin
            cal_state_q <= CAL_RUN;
            cal_cnt_q <= 16'(CAL_CYCLES - 1);
          end
        CAL_RUN:
          if (!timing_cal_start_q)
            cal_state_q <= CAL_IDLE;
          else if (cal_cnt_q == '0)
            cal_state_q <= CAL_DONE;
          else
            cal_cnt_q <= cal_cnt_q - 16'h0001;
        CAL_DONE:
          if (!timing_cal_start_q)
            cal_state_q <= CAL_IDLE;
        default:
          cal_state_q <= CAL_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      timing_cal_complete_q <= 1'b0;
      aperture_delay_q <= '0;
    end
    else
    begin
      timing_cal_complete_q <= timing_cal_start_q
        && cal_state_q == CAL_DONE
        && !(wr_at(req, ADDR_TIMING_CAL) && !req.wdata[BIT_CAL_EN]);
      if (!timing_cal_start_q)
        aperture_delay_q <= manual_delay;
      else if (cal_state_q == CAL_DONE)
        aperture_delay_q <= cal_result;
    end
  end

  // register read port, one cycle latency
  always_ff @(posedge clk)
  begin
    if (!resetn)
      rdata_q <= RST_ZERO8;
    else if (req.rd)
    begin
      rdata_q <= RST_ZERO8;
      case (req.addr)
        ADDR_LINK_STATUS:
        begin
          rdata_q[BIT_SYNC_STATUS] <= sync_q;
          rdata_q[BIT_REPHASE] <= rephase_q;
          rdata_q[BIT_PHASE_SET] <= phase_set_q;
        end
        ADDR_POWER_DOWN:
        begin
          rdata_q[BIT_PD_A] <= chan_a_powerdown_q;
          rdata_q[BIT_PD_B] <= chan_b_powerdown_q;
        end
        ADDR_OVR_THR_ZERO: rdata_q <= thr_zero_q;
        ADDR_OVR_THR_ONE: rdata_q <= thr_one_q;
        ADDR_OVR_CONFIG:
          rdata_q <= {4'h0, overrange_pin_enable_q, pulse_stretch_exponent_q};
        ADDR_SILICON_REV: rdata_q <= {3'h0, silicon_revision_id_q};
        ADDR_TIMING_CAL: rdata_q[BIT_CAL_EN] <= timing_cal_start_q;
        default: rdata_q <= RST_ZERO8;
      endcase
    end
  end

  // overrange pins: A zero, A one, B zero, B one
  csor_stretch u_a0 (
    .clk(clk), .resetn(resetn), .magnitude(mag8(samples.a)),
    .threshold(thr_zero_q), .enable(overrange_pin_enable_q),
    .exponent(pulse_stretch_exponent_q), .pin_q(chan_a_pin_zero));
  csor_stretch u_a1 (
    .clk(clk), .resetn(resetn), .magnitude(mag8(samples.a)),
    .threshold(thr_one_q), .enable(overrange_pin_enable_q),
    .exponent(pulse_stretch_exponent_q), .pin_q(chan_a_pin_one));
  csor_stretch u_b0 (
    .clk(clk), .resetn(resetn), .magnitude(mag8(samples.b)),
    .threshold(thr_zero_q), .enable(overrange_pin_enable_q),
    .exponent(pulse_stretch_exponent_q), .pin_q(chan_b_pin_zero));
  csor_stretch u_b1 (
    .clk(clk), .resetn(resetn), .magnitude(mag8(samples.b)),
    .threshold(thr_one_q), .enable(overrange_pin_enable_q),
    .exponent(pulse_stretch_exponent_q), .pin_q(chan_b_pin_one));

  sync_live_a: assert property (@(posedge clk)
    disable iff (!resetn)
    $past(req.rd) && $past(req.addr) == ADDR_LINK_STATUS
    |-> rdata_q[BIT_SYNC_STATUS] == $past(sync_q))
    else $error("sync bit does not track pin");
  rephase_set_a: assert property (@(posedge clk)
    disable iff (!resetn)
    realign_event |=> rephase_q && rephase_alarm_q)
    else $error("rephase flag not set");
  rephase_clr_a: assert property (@(posedge clk)
    disable iff (!resetn)
    !realign_event && wr_at(req, ADDR_LINK_STATUS)
    && req.wdata[BIT_REPHASE] && rephase_alarm_q
    |=> !rephase_q && rephase_alarm_q)
    else $error("rephase clear wrong");
  phase_set_a: assert property (@(posedge clk)
    disable iff (!resetn)
    sysref_edge && link_enable |=> phase_set_q)
    else $error("phase flag not set");
  zero_write_a: assert property (@(posedge clk)
    disable iff (!resetn)
    wr_at(req, ADDR_LINK_STATUS) && !req.wdata[BIT_PHASE_SET] && phase_set_q
    |=> phase_set_q)
    else $error("zero write cleared flag");
  powerdown_a: assert property (@(posedge clk)
    disable iff (!resetn)
    wr_at(req, ADDR_POWER_DOWN)
    |-> ##2 chan_a_lane_en_q == {14{~$past(req.wdata[BIT_PD_A], 2)}})
    else $error("channel lanes not gated by power-down");
  pins_low_a: assert property (@(posedge clk)
    disable iff (!resetn)
    !overrange_pin_enable_q |=> !chan_a_pin_zero && !chan_a_pin_one
    && !chan_b_pin_zero && !chan_b_pin_one)
    else $error("overrange pin high while disabled");
  manual_delay_a: assert property (@(posedge clk)
    disable iff (!resetn)
    !timing_cal_start_q |=> aperture_delay_q == $past(manual_delay))
    else $error("delay not following manual value");
  sequence cal_rise_s;
    !cal_en_prev_q ##1 timing_cal_start_q && cal_en_prev_q;
  endsequence
  cal_start_a: assert property (@(posedge clk)
    disable iff (!resetn)
    timing_cal_start_q && !cal_en_prev_q && cal_state_q == CAL_IDLE
    |=> cal_state_q == CAL_RUN)
    else $error("calibration not launched");
  cal_done_a: assert property (@(posedge clk)
    disable iff (!resetn)
    timing_cal_complete_q |-> timing_cal_start_q)
    else $error("done without enable");
  cal_runs_a: assert property (@(posedge clk)
    disable iff (!resetn)
    cal_rise_s |-> !timing_cal_complete_q)
    else $error("done reported at launch");
endmodule
`default_nettype wire

// ==== csor_host.sv ====
// host model issuing register writes and reads
`timescale 1ns/1ps
`default_nettype none
module csor_host
  import csor_pkg::*;
(
  input wire logic clk,
  input wire logic [7:0] rdata_q,
  output var csor_req_t req
);
  initial req = '0;

  // released bus shows inverted address and data
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(negedge clk);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge clk);
    req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask

  task automatic rd(input logic [11:0] a, output logic [7:0] d);
    @(negedge clk);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h5A};
    @(negedge clk);
    req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hA5};
    d = rdata_q;
  endtask
endmodule
`default_nettype wire

// ==== converter_status_overrange_regs_tb_top.sv ====
// self-checking bench for the status and overrange register bank
`timescale 1ns/1ps
`default_nettype none
module converter_status_overrange_regs_tb_top
  import csor_pkg::*;
;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic sync_pin = 1'b1;
  logic sysref_edge = 1'b0;
  logic realign_event = 1'b0;
  logic link_enable = 1'b0;
  logic [4:0] fuse_spin = 5'h0A;
  csor_samples_t samples = '0;
  logic [16:0] manual_delay = 17'h0;
  logic [16:0] cal_result = 17'h0;
  csor_req_t req;
  logic [7:0] rdata_q;
  logic pd_a, pd_b, a0, a1, b0, b1, done, alarm;
  logic [13:0] lane_a, lane_b;
  logic [16:0] delay;
  logic [31:0] seed = 32'h5011;
  int fails = 0;
  int n_checks = 0;
  int cyc = 0;

  csor_regs DUT (
    .clk(clk), .resetn(resetn), .req(req), .rdata_q(rdata_q),
    .sync_pin(sync_pin), .sysref_edge(sysref_edge),
    .realign_event(realign_event), .link_enable(link_enable),
    .fuse_spin(fuse_spin), .samples(samples),
    .manual_delay(manual_delay), .cal_result(cal_result),
    .chan_a_powerdown_q(pd_a), .chan_b_powerdown_q(pd_b),
    .chan_a_lane_en_q(lane_a), .chan_b_lane_en_q(lane_b),
    .chan_a_pin_zero(a0), .chan_a_pin_one(a1),
    .chan_b_pin_zero(b0), .chan_b_pin_one(b1),
    .aperture_delay_q(delay), .timing_cal_complete_q(done),
    .rephase_alarm_q(alarm)
  );

  csor_host host (.clk(clk), .rdata_q(rdata_q), .req(req));

  always #5 clk = ~clk;

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction

  // top eight bits of the saturated magnitude
  function automatic logic [7:0] mag8(input logic [11:0] s);
    logic [11:0] m;
    m = s[11] ? (~s + 12'h001) : s;
    if (m > 12'h7FF)
      m = 12'h7FF;
    return m[10:3];
  endfunction

  task automatic stop_test();
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      fails++;
      $display("BAD %s exp %0h got %0h", n, e, g);
    end
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [7:0] e);
    logic [7:0] d;
    host.rd(a, d);
    chk($sformatf("reg %0h", a), {24'h0, e}, {24'h0, d});
  endtask

  task automatic pulse_sref();
    @(negedge clk);
    sysref_edge = 1'b1;
    @(negedge clk);
    sysref_edge = 1'b0;
  endtask

  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 6000)
    begin
      fails++;
      stop_test();
    end
  end

  initial
  begin
    logic [7:0] d;
    logic [7:0] t0;
    logic [7:0] t1;
    logic [11:0] s;
    int n;
    seed = lfsr(seed);
    fuse_spin = seed[4:0];
    manual_delay = seed[24:8];
    repeat (20) @(negedge clk);
    resetn = 1'b1;
    rdchk(ADDR_POWER_DOWN, 8'h00);
    rdchk(ADDR_OVR_THR_ZERO, 8'hF2);
    rdchk(ADDR_OVR_THR_ONE, 8'hAB);
    rdchk(ADDR_OVR_CONFIG, 8'h07);
    rdchk(ADDR_TIMING_CAL, 8'h00);
    rdchk(12'h2A0, 8'h00);
    host.wr(ADDR_SILICON_REV, 8'hFF);
    rdchk(ADDR_SILICON_REV, {3'h0, fuse_spin});
    chk("delay", {15'h0, manual_delay}, {15'h0, delay});
    for (int i = 0; i < 2; i++)
    begin
      sync_pin = i[0];
      repeat (3) @(negedge clk);
      host.wr(ADDR_LINK_STATUS, {2'h0, ~i[0], 5'h0});
      host.rd(ADDR_LINK_STATUS, d);
      chk("sync", {31'h0, i[0]}, {31'h0, d[5]});
    end
    pulse_sref();
    rdchk(ADDR_LINK_STATUS, 8'h20);
    link_enable = 1'b1;
    @(negedge clk);
    realign_event = 1'b1;
    @(negedge clk);
    realign_event = 1'b0;
    pulse_sref();
    host.wr(ADDR_LINK_STATUS, 8'h00);
    rdchk(ADDR_LINK_STATUS, 8'h38);
    host.wr(ADDR_LINK_STATUS, 8'h10);
    rdchk(ADDR_LINK_STATUS, 8'h28);
    chk("alarm", 32'h1, {31'h0, alarm});
    // realign and write-one-clear on the same edge: the set must win
    realign_event = 1'b1;
    host.wr(ADDR_LINK_STATUS, 8'h10);
    realign_event = 1'b0;
    rdchk(ADDR_LINK_STATUS, 8'h38);
    host.wr(ADDR_LINK_STATUS, 8'h10);
    host.wr(ADDR_LINK_STATUS, 8'h08);
    rdchk(ADDR_LINK_STATUS, 8'h20);
    pulse_sref();
    rdchk(ADDR_LINK_STATUS, 8'h28);
    link_enable = 1'b0;
    for (int i = 1; i < 3; i++)
    begin
      host.wr(ADDR_POWER_DOWN, i[7:0]);
      rdchk(ADDR_POWER_DOWN, i[7:0]);
      chk("pd", i, {30'h0, pd_b, pd_a});
      chk("lane a", (i == 1) ? 0 : 32'h3FFF, {18'h0, lane_a});
      chk("lane b", (i == 2) ? 0 : 32'h3FFF, {18'h0, lane_b});
    end
    host.wr(ADDR_POWER_DOWN, 8'h00);
    host.wr(ADDR_OVR_CONFIG, 8'h08);
    for (int k = 0; k < 20; k++)
    begin
      seed = lfsr(seed);
      t0 = seed[19:12];
      t1 = seed[27:20];
      s = (k == 0) ? {1'b0, t0, 3'h0} : (k == 1) ? 12'h800 : seed[11:0];
      host.wr(ADDR_OVR_THR_ZERO, t0);
      host.wr(ADDR_OVR_THR_ONE, t1);
      @(negedge clk);
      samples = '{a: s, b: ~s};
      @(negedge clk);
      samples = '0;
      @(negedge clk);
      chk("a0", {31'h0, mag8(s) >= t0}, {31'h0, a0});
      chk("a1", {31'h0, mag8(s) >= t1}, {31'h0, a1});
      chk("b0", {31'h0, mag8(~s) >= t0}, {31'h0, b0});
      chk("b1", {31'h0, mag8(~s) >= t1}, {31'h0, b1});
      repeat (12) @(negedge clk);
    end
    host.wr(ADDR_OVR_THR_ONE, 8'h80);
    for (int e = 0; e < 8; e++)
    begin
      host.wr(ADDR_OVR_CONFIG, {5'h01, e[2:0]});
      @(negedge clk);
      samples.b = 12'h7FF;
      @(negedge clk);
      samples.b = 12'h000;
      n = 32'(b1);
      repeat ((8 << e) + 16)
      begin
        @(negedge clk);
        n += 32'(b1);
      end
      chk("pulse", 1, 32'(n >= (8 << e) && n <= (8 << e) + 2));
    end
    host.wr(ADDR_OVR_CONFIG, 8'h07);
    samples.b = 12'h7FF;
    repeat (3) @(negedge clk);
    chk("pin off", 0, {31'h0, b1});
    samples.b = 12'h000;
    seed = lfsr(seed);
    cal_result = seed[16:0];
    host.wr(ADDR_TIMING_CAL, 8'h01);
    repeat (CAL_CYCLES / 2) @(negedge clk);
    chk("done early", 0, {31'h0, done});
    manual_delay = ~manual_delay;
    repeat (CAL_CYCLES / 2 + 10) @(negedge clk);
    chk("done", 1, {31'h0, done});
    chk("delay cal", {15'h0, cal_result}, {15'h0, delay});
    host.wr(ADDR_TIMING_CAL, 8'h00);
    // done must drop on the same edge that clears the enable
    chk("done off", 0, {31'h0, done});
    @(negedge clk);
    chk("delay man", {15'h0, manual_delay}, {15'h0, delay});
    stop_test();
  end
endmodule
`default_nettype wire
